// ### hw/plms_lane_mapper.sv
// Maps captured half-words of two pixels onto panel colour words.
// Assumes halves are stable while the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module plms_lane_mapper
   import plms_pkg::*;
(
   input  wire logic [11:0] lo_a,
   input  wire logic [11:0] hi_a,
   input  wire logic [11:0] lo_b,
   input  wire logic [11:0] hi_b,
   input  wire logic [1:0]  lane_mode,
   input  wire logic        panel18,
   output plms_rgb_t        pix_a,
   output plms_rgb_t        pix_b,
   output logic [7:0]       lane_en
);

   function automatic plms_rgb_t to_rgb(input logic [11:0] lo, input logic [11:0] hi,
                                        input logic p18);
      plms_rgb_t px;
      px.r = hi[11:4];
      px.g = {hi[3:0], lo[11:8]};
      px.b = lo[7:0];
      if (p18) begin
         px.r[1:0] = 2'h0;
         px.g[1:0] = 2'h0;
         px.b[1:0] = 2'h0;
      end
      return px;
   endfunction : to_rgb

   assign pix_a   = to_rgb(lo_a, hi_a, panel18);
   assign pix_b   = to_rgb(lo_b, hi_b, panel18);
   assign lane_en = (lane_mode == LANE_SINGLE_IN_SINGLE_OUT) ? LANES_SINGLE : LANES_DUAL;

endmodule : plms_lane_mapper
`default_nettype wire

// ### hw/plms_timing_meas.sv
// Measures input sync widths, totals and active window in pixel ticks or lines.
// Assumes hs, vs and de are synchronised and active high.
`timescale 1ns/1ps
`default_nettype none
module plms_timing_meas
   import plms_pkg::*;
(
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic clk_en,
   input  wire logic tick,
   input  wire logic hs,
   input  wire logic vs,
   input  wire logic de_act,
   output plms_meas_t meas
);

   logic [11:0] pix_reg, line_reg, hsw_reg, vsw_reg;
   logic        hs_prev_reg, vs_prev_reg, de_prev_reg;
   plms_meas_t  meas_reg;
   wire         hs_rise = hs & ~hs_prev_reg;
   wire         vs_rise = vs & ~vs_prev_reg;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {hs_prev_reg, vs_prev_reg, de_prev_reg} <= 3'h0;
         {pix_reg, line_reg, hsw_reg, vsw_reg}   <= 48'h0;
         meas_reg                                <= '0;
      end else if (clk_en) begin
         {hs_prev_reg, vs_prev_reg, de_prev_reg} <= {hs, vs, de_act};
         pix_reg  <= hs_rise ? 12'h000 : pix_reg + 12'(tick);
         hsw_reg  <= hs_rise ? 12'h000 : hsw_reg + 12'(tick & hs);
         line_reg <= vs_rise ? 12'h000 : line_reg + 12'(hs_rise);
         vsw_reg  <= vs_rise ? 12'h000 : vsw_reg + 12'(hs_rise & vs);
         if (hs_rise) meas_reg.ppl <= pix_reg;
         if (hs_prev_reg & ~hs) meas_reg.hs_w <= hsw_reg;
         if (vs_rise) meas_reg.lines <= line_reg;
         if (vs_prev_reg & ~vs) meas_reg.vs_w <= vsw_reg;
         if (de_act & ~de_prev_reg) meas_reg.act_s <= pix_reg;
         if (~de_act & de_prev_reg) meas_reg.act_e <= pix_reg;
      end
   end

   assign meas = meas_reg;

endmodule : plms_timing_meas
`default_nettype wire

// ### hw/plms_top.sv
// Double-edge pixel capture, lane mapping, scaler bypass and display sync.
// Assumes pins come from outside the mclk domain; registers on AXI4-Lite.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module plms_top
   import plms_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic              clk_en,
   input  wire plms_pins_t        pins,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output plms_rgb_t              lane_pix_a,
   output plms_rgb_t              lane_pix_b,
   output logic [7:0]             lane_en,
   output logic                   pix_valid,
   output plms_rgb_t              scaler_pix,
   output logic                   scaler_pix_valid,
   output logic                   scaler_bypass,
   output logic                   scaler_off,
   output logic                   out_hsync,
   output logic                   out_vsync
);

   // Pin synchroniser; meta stage feeds only the second stage
   plms_pins_t pins_meta_reg, pins_s_reg, pins_d_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pins_meta_reg <= '0;
         pins_s_reg    <= '0;
         pins_d_reg    <= '0;
      end else if (clk_en) begin
         pins_meta_reg <= pins;
         pins_s_reg    <= pins_meta_reg;
         pins_d_reg    <= pins_s_reg;
      end
   end

   // Registers
   logic [5:0]  ctrl_reg;
   logic [7:0]  rate_reg;
   logic [11:0] htot_reg, vtot_reg;
   wire         pol       = ctrl_reg[CTRL_POL];
   wire [1:0]   sync_mode = ctrl_reg[CTRL_SYNC +: 2];
   wire         panel18   = ctrl_reg[CTRL_P18];
   wire         se_clk    = ctrl_reg[CTRL_SE_CLK];
   wire         edge_sel  = ctrl_reg[CTRL_EDGE];
   wire [1:0]   lane_mode = pins_d_reg.lane;
   wire         dual_in   = (lane_mode == LANE_DUAL_IN_DUAL_OUT);
   wire         single_in_dual_out      = (lane_mode == LANE_SINGLE_IN_DUAL_OUT);
   wire         de_act    = (pins_d_reg.de == pol);

   // Input clock level: differential holds until the pair crosses
   logic clk_lvl_reg, clk_prev_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         clk_lvl_reg  <= 1'b0;
         clk_prev_reg <= 1'b0;
      end else if (clk_en) begin
         if (se_clk || (pins_s_reg.clk_p != pins_s_reg.clk_m))
            clk_lvl_reg <= pins_s_reg.clk_p;
         clk_prev_reg <= clk_lvl_reg;
      end
   end
   wire clk_rise = clk_lvl_reg & ~clk_prev_reg;
   wire clk_fall = ~clk_lvl_reg & clk_prev_reg;
   wire prim     = edge_sel ? clk_fall : clk_rise;
   wire sec      = edge_sel ? clk_rise : clk_fall;

   // Capture of halves
   plms_cap_t   cap_state;
   logic [11:0] lo_a_reg, hi_a_reg, lo_b_reg, hi_b_reg;
   logic        done_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cap_state <= CAP_FIRST;
         {lo_a_reg, hi_a_reg, lo_b_reg, hi_b_reg} <= 48'h0;
         done_reg  <= 1'b0;
      end else if (clk_en) begin
         done_reg <= 1'b0;
         if (!de_act) begin
            cap_state <= CAP_FIRST;
         end else begin
            case (cap_state)
               CAP_FIRST: begin
                  if (prim) begin
                     lo_a_reg <= pins_d_reg.d[11:0];
                     lo_b_reg <= dual_in ? pins_d_reg.d[23:12] : 12'h000;
                  end else if (sec) begin
                     hi_a_reg <= pins_d_reg.d[11:0];
                     hi_b_reg <= dual_in ? pins_d_reg.d[23:12] : 12'h000;
                     if (single_in_dual_out)
                        cap_state <= CAP_SECOND;
                     else
                        done_reg <= 1'b1;
                  end
               end
               CAP_SECOND: begin
                  if (prim) begin
                     lo_b_reg <= pins_d_reg.d[11:0];
                  end else if (sec) begin
                     hi_b_reg  <= pins_d_reg.d[11:0];
                     done_reg  <= 1'b1;
                     cap_state <= CAP_FIRST;
                  end
               end
               default: cap_state <= CAP_FIRST;
            endcase
         end
      end
   end

   // Lane mapping and output stage
   plms_rgb_t  map_a, map_b;
   logic [7:0] map_en;
   plms_lane_mapper u_map (
      .lo_a      (lo_a_reg),
      .hi_a      (hi_a_reg),
      .lo_b      (lo_b_reg),
      .hi_b      (hi_b_reg),
      .lane_mode (lane_mode),
      .panel18   (panel18),
      .pix_a     (map_a),
      .pix_b     (map_b),
      .lane_en   (map_en)
   );

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lane_pix_a       <= '0;
         lane_pix_b       <= '0;
         lane_en          <= 8'h00;
         pix_valid        <= 1'b0;
         scaler_pix       <= '0;
         scaler_pix_valid <= 1'b0;
         scaler_bypass    <= 1'b0;
         scaler_off       <= 1'b0;
      end else if (clk_en) begin
         lane_en          <= map_en;
         pix_valid        <= done_reg;
         scaler_bypass    <= dual_in | (rate_reg > BYPASS_MHZ);
         scaler_off       <= dual_in;
         scaler_pix_valid <= done_reg & ~dual_in & (rate_reg <= BYPASS_MHZ);
         if (done_reg) begin
            lane_pix_a <= map_a;
            lane_pix_b <= (lane_mode == LANE_SINGLE_IN_SINGLE_OUT) ? '0 : map_b;
            scaler_pix <= map_a;
         end
      end
   end

   // Input timing measurement
   plms_meas_t meas;
   plms_timing_meas u_meas (
      .mclk    (mclk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .tick    (prim),
      .hs      (pins_d_reg.hs),
      .vs      (pins_d_reg.vs),
      .de_act  (de_act),
      .meas    (meas)
   );

   // Output display timing
   logic        ref_prev_reg, in_hs_prev_reg, in_vs_prev_reg;
   logic [11:0] h_cnt_reg, v_cnt_reg;
   wire         ref_tick  = pins_s_reg.ref_clk & ~ref_prev_reg;
   wire         in_hs_ris = pins_d_reg.hs & ~in_hs_prev_reg;
   wire         in_vs_ris = pins_d_reg.vs & ~in_vs_prev_reg;
   wire         h_wrap    = (h_cnt_reg >= htot_reg - 12'h001);
   wire         v_wrap    = (v_cnt_reg >= vtot_reg - 12'h001);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {ref_prev_reg, in_hs_prev_reg, in_vs_prev_reg} <= 3'h0;
         h_cnt_reg <= 12'h000;
         v_cnt_reg <= 12'h000;
      end else if (clk_en) begin
         ref_prev_reg   <= pins_s_reg.ref_clk;
         in_hs_prev_reg <= pins_d_reg.hs;
         in_vs_prev_reg <= pins_d_reg.vs;
         if (sync_mode == SYNC_LINE && in_hs_ris) begin
            h_cnt_reg <= 12'h000;
            v_cnt_reg <= v_wrap ? 12'h000 : v_cnt_reg + 12'h001;
         end else if (sync_mode == SYNC_FRAME && in_vs_ris) begin
            h_cnt_reg <= 12'h000;
            v_cnt_reg <= 12'h000;
         end else if (ref_tick) begin
            h_cnt_reg <= h_wrap ? 12'h000 : h_cnt_reg + 12'h001;
            if (h_wrap)
               v_cnt_reg <= v_wrap ? 12'h000 : v_cnt_reg + 12'h001;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         out_hsync <= 1'b0;
         out_vsync <= 1'b0;
      end else if (clk_en) begin
         out_hsync <= (h_cnt_reg < OUT_HS_W);
         out_vsync <= (v_cnt_reg < OUT_VS_W);
      end
   end

   // AXI4-Lite slave
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      return a[1:0] == 2'h0 && a <= ADDR_W'(OFS_M_ACTE);
   endfunction : addr_ok

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction : merge

   logic              aw_got_reg, w_got_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0]       w_data_reg;
   logic [3:0]        w_strb_reg;
   wire               wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {aw_got_reg, w_got_reg} <= 2'h0;
         aw_addr_reg   <= '0;
         w_data_reg    <= 32'h0;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg    <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg    <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            {aw_got_reg, w_got_reg} <= 2'h0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_ok(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= CTRL_RST;
         rate_reg <= RATE_RST;
         htot_reg <= HTOT_RST;
         vtot_reg <= VTOT_RST;
      end else if (clk_en && wr_fire) begin
         case (8'(aw_addr_reg))
            OFS_CTRL: ctrl_reg <= 6'(merge(32'(ctrl_reg), w_data_reg, w_strb_reg));
            OFS_RATE: rate_reg <= 8'(merge(32'(rate_reg), w_data_reg, w_strb_reg));
            OFS_HTOT: htot_reg <= 12'(merge(32'(htot_reg), w_data_reg, w_strb_reg));
            OFS_VTOT: vtot_reg <= 12'(merge(32'(vtot_reg), w_data_reg, w_strb_reg));
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (8'(s_axi_araddr))
               OFS_CTRL:   s_axi_rdata <= 32'(ctrl_reg);
               OFS_RATE:   s_axi_rdata <= 32'(rate_reg);
               OFS_HTOT:   s_axi_rdata <= 32'(htot_reg);
               OFS_VTOT:   s_axi_rdata <= 32'(vtot_reg);
               OFS_STAT:   s_axi_rdata <= 32'({scaler_off, scaler_bypass, lane_mode});
               OFS_M_HSW:  s_axi_rdata <= 32'(meas.hs_w);
               OFS_M_VSW:  s_axi_rdata <= 32'(meas.vs_w);
               OFS_M_PPL:  s_axi_rdata <= 32'(meas.ppl);
               OFS_M_LINE: s_axi_rdata <= 32'(meas.lines);
               OFS_M_ACTS: s_axi_rdata <= 32'(meas.act_s);
               OFS_M_ACTE: s_axi_rdata <= 32'(meas.act_e);
               default:    s_axi_rdata <= 32'h0;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence s_first_low;
      clk_en && de_act && prim && cap_state == CAP_FIRST;
   endsequence
   sequence s_pixel_done;
      clk_en && done_reg;
   endsequence

   chk_low_half_latch: assert property (s_first_low |=> lo_a_reg == $past(pins_d_reg.d[11:0]))
      else $error("low half not latched on primary edge");
   chk_second_pair_single_in_dual_out: assert property (cap_state == CAP_SECOND |-> single_in_dual_out)
      else $error("second pixel phase outside single-dual mode");
   chk_upper_lines_gate: assert property ((s_first_low and !dual_in) |=> lo_b_reg == 12'h000)
      else $error("upper lines taken without dual input");
   chk_single_lanes: assert property (clk_en && lane_mode == LANE_SINGLE_IN_SINGLE_OUT |=> lane_en == LANES_SINGLE)
      else $error("single mode enables more than four lanes");
   chk_second_pixel_out: assert property ((s_pixel_done and single_in_dual_out) |=> lane_pix_b == $past(map_b))
      else $error("second pixel not on upper lanes");
   chk_enable_polarity: assert property (clk_en && pol && !pins_d_reg.de |-> !de_act)
      else $error("enable polarity ignored");
   chk_bypass_select: assert property (clk_en && dual_in |=> scaler_bypass && scaler_off)
      else $error("dual input did not bypass scaler");
   chk_free_run_hold: assert property (clk_en && sync_mode == SYNC_FREE && !ref_tick
                                       |=> h_cnt_reg == $past(h_cnt_reg))
      else $error("free run moved without reference tick");
   chk_line_lock: assert property (clk_en && sync_mode == SYNC_LINE && in_hs_ris |=> h_cnt_reg == 12'h000)
      else $error("line lock did not restart line");
   chk_frame_lock: assert property (clk_en && sync_mode == SYNC_FRAME && in_vs_ris
                                    |=> v_cnt_reg == 12'h000 ##1 out_vsync)
      else $error("frame lock did not restart frame");

endmodule : plms_top
`default_nettype wire

// ### include/plms_pkg.sv
// Shared types and constants for the pixel lane mapper with display sync.
// Assumes one 50 MHz core clock; all pins are synchronised inside the top.
package plms_pkg;

   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } plms_rgb_t;

   // Pin bundle passed through the synchroniser as one word
   typedef struct packed {
      logic        clk_p;
      logic        clk_m;
      logic        ref_clk;
      logic [1:0]  lane;
      logic        de;
      logic        hs;
      logic        vs;
      logic [23:0] d;
   } plms_pins_t;

   typedef struct packed {
      logic [11:0] hs_w;
      logic [11:0] vs_w;
      logic [11:0] ppl;
      logic [11:0] lines;
      logic [11:0] act_s;
      logic [11:0] act_e;
   } plms_meas_t;

   typedef enum logic [1:0] {
      CAP_FIRST  = 2'b01,
      CAP_SECOND = 2'b10
   } plms_cap_t;

   localparam logic [1:0] LANE_SINGLE_IN_SINGLE_OUT = 2'h0;
   localparam logic [1:0] LANE_SINGLE_IN_DUAL_OUT = 2'h1;
   localparam logic [1:0] LANE_DUAL_IN_DUAL_OUT = 2'h3;

   localparam logic [1:0] SYNC_FREE  = 2'h0;
   localparam logic [1:0] SYNC_LINE  = 2'h1;
   localparam logic [1:0] SYNC_FRAME = 2'h2;

   localparam logic [7:0] LANES_SINGLE = 8'h0F;
   localparam logic [7:0] LANES_DUAL   = 8'hFF;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_RATE   = 8'h04;
   localparam logic [7:0] OFS_HTOT   = 8'h08;
   localparam logic [7:0] OFS_VTOT   = 8'h0C;
   localparam logic [7:0] OFS_STAT   = 8'h10;
   localparam logic [7:0] OFS_M_HSW  = 8'h14;
   localparam logic [7:0] OFS_M_VSW  = 8'h18;
   localparam logic [7:0] OFS_M_PPL  = 8'h1C;
   localparam logic [7:0] OFS_M_LINE = 8'h20;
   localparam logic [7:0] OFS_M_ACTS = 8'h24;
   localparam logic [7:0] OFS_M_ACTE = 8'h28;

   // Control field positions
   localparam int CTRL_POL    = 0;
   localparam int CTRL_SYNC   = 1;
   localparam int CTRL_P18    = 3;
   localparam int CTRL_SE_CLK = 4;
   localparam int CTRL_EDGE   = 5;

   localparam logic [5:0]  CTRL_RST = 6'h01;
   localparam logic [7:0]  RATE_RST = 8'h00;
   localparam logic [11:0] HTOT_RST = 12'h320;
   localparam logic [11:0] VTOT_RST = 12'h20D;

   localparam logic [7:0]  BYPASS_MHZ = 8'h6C;
   localparam logic [11:0] OUT_HS_W   = 12'h060;
   localparam logic [11:0] OUT_VS_W   = 12'h002;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : plms_pkg

// ### test/plms_gfx_model.sv
// Graphics controller model: double-edge pixel halves on d.
// Assumes bench mclk paces it; link clock idles low.
`timescale 1ns/1ps
`default_nettype none
module plms_gfx_model (
   input  wire logic        mclk,
   output logic             clk_p,
   output logic             clk_m,
   output logic [23:0]      d
);
   initial begin
      clk_p = 1'b0;
      clk_m = 1'b1;
      d     = 24'h000000;
   end
   // One half: data held 40 ns before and 20 ns after the edge
   task automatic half(input logic [23:0] v);
      d <= v;
      repeat (2) @(posedge mclk);
      clk_p <= ~clk_p;
      clk_m <= clk_p;
      @(posedge mclk);
      d <= ~v;
      @(posedge mclk);
   endtask : half
   task automatic pix(input logic [23:0] lo, input logic [23:0] hi);
      half(lo);
      half(hi);
   endtask : pix
endmodule : plms_gfx_model
`default_nettype wire

// ### test/plms_top_tb.sv
// Bench for plms_top: AXI4-Lite tasks and pixel mapping checks.
// Assumes plms_pkg and the controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module plms_top_tb;
   import plms_pkg::*;
   logic mclk, reset_n, ref_clk, de, clk_p, clk_m, hs, vs, out_hsync, out_vsync, scaler_pix_valid;
   logic [1:0] lane, s_axi_bresp, s_axi_rresp, rsp;
   logic [23:0] d;
   logic [7:0] s_axi_awaddr, s_axi_araddr, lane_en;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pix_valid;
   plms_rgb_t pa, pb, sp, lane_pix_a, lane_pix_b, scaler_pix;
   int n_fail, comparisons, n_pix, n_sp, cyc;
   plms_pins_t pins;
   assign pins = {clk_p, clk_m, ref_clk, lane, de, hs, vs, d};
   plms_gfx_model gfx (.mclk(mclk), .clk_p(clk_p), .clk_m(clk_m), .d(d));
   plms_top dut (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .pins(pins), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .lane_pix_a(lane_pix_a), .lane_pix_b(lane_pix_b), .lane_en(lane_en), .pix_valid(pix_valid),
      .scaler_pix(scaler_pix), .scaler_pix_valid(scaler_pix_valid), .scaler_bypass(), .scaler_off(),
      .out_hsync(out_hsync), .out_vsync(out_vsync));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      ref_clk <= cyc[2];
      if (pix_valid === 1'b1) begin
         pa <= lane_pix_a;
         pb <= lane_pix_b;
         n_pix <= n_pix + 1;
      end
      if (scaler_pix_valid === 1'b1) begin
         sp <= scaler_pix;
         n_sp <= n_sp + 1;
      end
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (n_fail == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w) begin
         @(posedge mclk);
         if (s_axi_awready) aw = 1'b0;
         if (s_axi_wready) w = 1'b0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      while (s_axi_bvalid !== 1'b1) @(posedge mclk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask : rd
   // Wait for the n-th pixel, bounded
   task automatic wpx(input int n);
      int k;
      k = 0;
      while (n_pix < n && k < 40) begin
         @(posedge mclk);
         k++;
      end
   endtask : wpx
   initial begin
      {reset_n, ref_clk, de, hs, vs, lane, cyc, n_pix, n_sp, n_fail, comparisons} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      rd(OFS_CTRL);
      chk(rv, 32'h00000001);
      rd(OFS_STAT);
      chk(rv, 32'h00000000);
      de <= 1'b1;
      gfx.pix(24'h000A5C, 24'h0003B7);
      wpx(1);
      chk(pa, 24'h3B7A5C);
      chk(sp, 24'h3B7A5C);
      chk({pb, lane_en}, 32'h0000000F);
      wr(OFS_CTRL, 32'h00000018);
      chk(rsp, RESP_OKAY);
      de <= 1'b0;
      gfx.pix(24'h000FFF, 24'h000FFF);
      wpx(2);
      chk(pa, 24'hFCFCFC);
      de <= 1'b1;
      gfx.pix(24'h000123, 24'h000456);
      repeat (8) @(posedge mclk);
      chk(n_pix, 2);
      wr(OFS_CTRL, 32'h00000001);
      lane <= LANE_SINGLE_IN_DUAL_OUT;
      gfx.pix(24'h000111, 24'h000222);
      gfx.pix(24'h000333, 24'h000444);
      wpx(3);
      chk(pa, 24'h222111);
      chk({pb, lane_en}, 32'h444333FF);
      de <= 1'b0;
      lane <= LANE_DUAL_IN_DUAL_OUT;
      repeat (6) @(posedge mclk);
      de <= 1'b1;
      gfx.pix(24'hABC5A5, 24'hDEF3C3);
      wpx(4);
      chk(pa, 24'h3C35A5);
      chk(pb, 24'hDEFABC);
      chk(n_sp, 3);
      rd(OFS_STAT);
      chk(rv, 32'h0000000F);
      de <= 1'b0;
      lane <= LANE_SINGLE_IN_SINGLE_OUT;
      wr(OFS_RATE, 32'h0000006D);
      rd(OFS_STAT);
      chk(rv, 32'h00000004);
      wr(OFS_RATE, 32'h0000006C);
      rd(OFS_STAT);
      chk(rv, 32'h00000000);
      wr(OFS_CTRL, 32'h00000003);
      hs <= 1'b1;
      repeat (2) gfx.pix(24'h000000, 24'h000000);
      hs <= 1'b0;
      gfx.pix(24'h000000, 24'h000000);
      de <= 1'b1;
      repeat (2) gfx.pix(24'h000000, 24'h000000);
      de <= 1'b0;
      gfx.pix(24'h000000, 24'h000000);
      hs <= 1'b1;
      repeat (6) @(posedge mclk);
      rd(OFS_M_HSW);
      chk(rv, 32'h00000002);
      rd(OFS_M_ACTS);
      chk(rv, 32'h00000003);
      rd(OFS_M_ACTE);
      chk(rv, 32'h00000005);
      rd(OFS_M_PPL);
      chk(rv, 32'h00000006);
      wr(OFS_HTOT, 32'h00000001);
      wr(OFS_CTRL, 32'h00000005);
      repeat (40) @(posedge mclk);
      chk({out_hsync, out_vsync}, 32'h00000002);
      vs <= 1'b1;
      repeat (6) @(posedge mclk);
      chk(out_vsync, 1'b1);
      rd(8'h2C);
      chk(rsp, RESP_SLVERR);
      chk(rv, 32'h00000000);
      wr(8'h2C, 32'h00000001);
      chk(rsp, RESP_SLVERR);
      complete_run();
   end
endmodule : plms_top_tb
`default_nettype wire
